/* rtl/ladder_pkg_mem.sv */
// constants, instruction layout and the program memory of the ladder evaluator
`timescale 1ns/100ps
package ladder_pkg;
  localparam int PROG_WORDS = 144;
  localparam int ADDR_W = 8;
  localparam logic [7:0] PROG_FIRST = 8'h00;
  localparam logic [7:0] PROG_LAST = 8'h8F;
  localparam int CH_BITS = 16;
  localparam int STACK_DEPTH = 8;
  // function codes
  localparam logic [7:0] FC_NOP = 8'h00;
  localparam logic [7:0] FC_END = 8'h01;
  localparam logic [7:0] FC_LD = 8'h40;
  localparam logic [7:0] FC_LDN = 8'h41;
  localparam logic [7:0] FC_AND = 8'h42;
  localparam logic [7:0] FC_ANDN = 8'h43;
  localparam logic [7:0] FC_OR = 8'h44;
  localparam logic [7:0] FC_ORN = 8'h45;
  localparam logic [7:0] FC_BLK_AND = 8'h46;
  localparam logic [7:0] FC_BLK_OR = 8'h47;
  localparam logic [7:0] FC_OUT = 8'h48;
  localparam logic [7:0] FC_OUTN = 8'h49;
  // bit address channels
  localparam logic [7:0] CH_IN = 8'h00;
  localparam logic [7:0] CH_OUT = 8'h01;
  localparam logic [7:0] CH_WORK = 8'h02;
  localparam logic [15:0] IMAGE_RESET = 16'h0000;
  // one program line: function code, then a four-digit bit address
  typedef struct packed {
    logic [7:0] func;
    logic [7:0] chan;
    logic [7:0] bitSel;
  } instr_s;
  localparam int INSTR_W = $bits(instr_s);
  localparam instr_s INSTR_RESET = '{func: FC_NOP, chan: 8'h00, bitSel: 8'h00};
endpackage

// program store with separate write and read addresses, registered read data
module ladder_prog_mem #(
  parameter int DEPTH = ladder_pkg::PROG_WORDS,
  parameter int AW = ladder_pkg::ADDR_W
) (
  input wire logic ref_clk, // system clock
  input wire logic wrEn, // write strobe
  input wire logic [AW-1:0] wrAddr, // write address
  input wire ladder_pkg::instr_s wrData, // write data
  input wire logic [AW-1:0] rdAddr, // read address
  output ladder_pkg::instr_s rdData // read data, one cycle late
);
  ladder_pkg::instr_s mem [DEPTH];

  // write and registered read; out-of-range writes dropped
  always_ff @(posedge ref_clk)
  begin
    if (wrEn && (int'(wrAddr) < DEPTH))
      mem[wrAddr] <= wrData;
    rdData <= (int'(rdAddr) < DEPTH) ? mem[rdAddr] : ladder_pkg::INSTR_RESET;
  end
endmodule

/* rtl/ladder_bit_logic_evaluator.sv */
// ladder bit-logic evaluator: scan engine, condition logic and bit image
`timescale 1ns/100ps

// Functional notes
// [RQ1] series/parallel ops combine condition with operand bit, negated forms invert
// [RQ2] direct output drives its bit equal to the condition each scan
// [RQ3] inverted output drives its bit opposite to the condition
// [RQ4] both output forms use one program line with the operand inline
// [RQ5] bits 0000/0001 are inputs 0/1; bits 0100/0101 drive outputs 0/1
// [RQ6] scan runs in address order to first end, then restarts at 000
// [RQ7] nothing after the first end instruction is ever executed
// [RQ8] end instruction has function code 01
// [RQ9] end takes no operand and ignores the execution condition
// [RQ10] without any end instruction in memory nothing executes
// [RQ11] mid-line block-start load pushes the condition, then loads operand
// [RQ12] only a mid-line block-start load creates a saved condition
// [RQ13] block-and ANDs condition with last saved one and pops it
// [RQ14] block-or is like block-and but ORs
// [RQ15] block-combining ops take no operand, use earlier conditions only
// [RQ16] block-start load sets condition to operand, negated form to its inverse
// [RQ17] program memory runs from 000 for 144 one-line words
// [RQ18] saved conditions form a stack, cleared at the start of each scan
// [RQ19] block op on empty stack keeps condition and flags a program error
module ladder_bit_logic_evaluator #(
  parameter int NUM_IN = ladder_pkg::CH_BITS,
  parameter int NUM_OUT = ladder_pkg::CH_BITS,
  parameter int STACK_DEPTH = ladder_pkg::STACK_DEPTH
) (
  input wire logic ref_clk, // system clock, 250 MHz
  input wire logic nrst, // synchronous reset, active low
  input wire logic [NUM_IN-1:0] inPins, // physical inputs, asynchronous
  output logic [NUM_OUT-1:0] outPins, // physical outputs
  input wire logic progWe, // program write strobe
  input wire logic [ladder_pkg::ADDR_W-1:0] progAddr, // program write address
  input wire ladder_pkg::instr_s progData, // program write word
  output logic running, // executing instructions this scan
  output logic scanDone, // pulse when an end instruction is executed
  output logic progError // sticky block-op-on-empty-stack flag
);
  typedef enum logic [1:0] {SEEK_FETCH, SEEK_CHECK, RUN_FETCH, RUN_EXEC} scan_e;
  localparam int CNT_W = $clog2(STACK_DEPTH + 1);
  localparam logic [CNT_W-1:0] CNT_FULL = CNT_W'(STACK_DEPTH);

  scan_e state_reg, state_next;
  logic [7:0] pc_reg, pc_next;
  logic [7:0] endAddr_reg, endAddr_next;
  logic cond_reg, cond_next;
  logic lineStart_reg, lineStart_next;
  logic [STACK_DEPTH-1:0] stack_reg, stack_next;
  logic [CNT_W-1:0] stackCnt_reg, stackCnt_next;
  logic [NUM_OUT-1:0] outImg_reg, outImg_next;
  logic [ladder_pkg::CH_BITS-1:0] work_reg, work_next;
  logic err_reg, err_next;
  logic done_reg, done_next;
  logic [NUM_IN-1:0] inMeta_reg, inSync_reg;
  ladder_pkg::instr_s instr;

  // bcd bit number 00..15 to index; bit 4 set marks an invalid number
  function automatic logic [4:0] bitIndex(input logic [7:0] bcd);
    logic [4:0] idx;
    idx = 5'h10;
    if (bcd[7:4] == 4'h0 && bcd[3:0] <= 4'h9)
      idx = {1'b0, bcd[3:0]};
    else if (bcd[7:4] == 4'h1 && bcd[3:0] <= 4'h5)
      idx = 5'(bcd[3:0]) + 5'h0A;
    return idx;
  endfunction

  // [RQ17] program store
  ladder_prog_mem #(.DEPTH(ladder_pkg::PROG_WORDS), .AW(ladder_pkg::ADDR_W)) progMem (
    .ref_clk(ref_clk),
    .wrEn(progWe),
    .wrAddr(progAddr),
    .wrData(progData),
    .rdAddr(pc_reg),
    .rdData(instr)
  );

  // operand decode
  wire logic [4:0] opIdx = bitIndex(instr.bitSel);
  wire logic opValid = !opIdx[4];
  wire logic [ladder_pkg::CH_BITS-1:0] inWide = ladder_pkg::CH_BITS'(inSync_reg);
  wire logic [ladder_pkg::CH_BITS-1:0] outWide = ladder_pkg::CH_BITS'(outImg_reg);
  // [RQ5] channel 00 reads inputs, channel 01 the output image
  wire logic [ladder_pkg::CH_BITS-1:0] chanWord =
    (instr.chan == ladder_pkg::CH_IN) ? inWide :
    (instr.chan == ladder_pkg::CH_OUT) ? outWide :
    (instr.chan == ladder_pkg::CH_WORK) ? work_reg : ladder_pkg::IMAGE_RESET;
  wire logic opBit = opValid && chanWord[opIdx[3:0]];
  // odd load, and, or and output codes are the negated forms
  wire logic litBit = opBit ^ instr.func[0];
  wire logic outVal = cond_reg ^ instr.func[0];
  wire logic execNow = (state_reg == RUN_EXEC);
  wire logic isEnd = (instr.func == ladder_pkg::FC_END);
  wire logic isLoad = (instr.func == ladder_pkg::FC_LD) || (instr.func == ladder_pkg::FC_LDN);
  wire logic isBlk = (instr.func == ladder_pkg::FC_BLK_AND) || (instr.func == ladder_pkg::FC_BLK_OR);
  wire logic isOut = (instr.func == ladder_pkg::FC_OUT) || (instr.func == ladder_pkg::FC_OUTN);
  wire logic stackEmpty = (stackCnt_reg == '0);

  // input synchroniser, two flops
  always_ff @(posedge ref_clk)
  begin
    inMeta_reg <= inPins;
    inSync_reg <= inMeta_reg;
  end

  // scan sequencing
  always_comb
  begin
    state_next = state_reg;
    pc_next = pc_reg;
    endAddr_next = endAddr_reg;
    done_next = 1'b0;
    unique case (state_reg)
      SEEK_FETCH:
        state_next = SEEK_CHECK;
      SEEK_CHECK:
      begin
        // [RQ10] run only once an end instruction is located
        if (isEnd)
        begin
          endAddr_next = pc_reg;
          pc_next = ladder_pkg::PROG_FIRST;
          state_next = RUN_FETCH;
        end
        else
        begin
          pc_next = (pc_reg == ladder_pkg::PROG_LAST) ? ladder_pkg::PROG_FIRST : pc_reg + 8'h01;
          state_next = SEEK_FETCH;
        end
      end
      RUN_FETCH:
        state_next = RUN_EXEC;
      RUN_EXEC:
      begin
        // [RQ6] [RQ7] [RQ8] stop at first end, restart from 000
        if (isEnd || pc_reg == endAddr_reg)
        begin
          done_next = isEnd;
          pc_next = ladder_pkg::PROG_FIRST;
          state_next = SEEK_FETCH;
        end
        else
        begin
          pc_next = pc_reg + 8'h01;
          state_next = RUN_FETCH;
        end
      end
    endcase
  end

  // condition, stack and bit image
  always_comb
  begin
    cond_next = cond_reg;
    lineStart_next = lineStart_reg;
    stack_next = stack_reg;
    stackCnt_next = stackCnt_reg;
    outImg_next = outImg_reg;
    work_next = work_reg;
    err_next = err_reg;
    if (state_reg == SEEK_CHECK && isEnd)
    begin
      // [RQ18] fresh stack and line at scan start
      stack_next = '0;
      stackCnt_next = '0;
      cond_next = 1'b0;
      lineStart_next = 1'b1;
    end
    // [RQ9] end ignores condition
    else if (execNow && !isEnd)
    begin
      unique case (instr.func)
        ladder_pkg::FC_LD, ladder_pkg::FC_LDN:
        begin
          // [RQ11] [RQ12] mid-line load saves condition
          if (!lineStart_reg)
          begin
            stack_next = {stack_reg[STACK_DEPTH-2:0], cond_reg};
            stackCnt_next = (stackCnt_reg == CNT_FULL) ? stackCnt_reg : stackCnt_reg + CNT_W'(1);
          end
          // [RQ16] load operand
          cond_next = litBit;
          lineStart_next = 1'b0;
        end
        // [RQ1] series and parallel conditions
        ladder_pkg::FC_AND, ladder_pkg::FC_ANDN:
          cond_next = cond_reg & litBit;
        ladder_pkg::FC_OR, ladder_pkg::FC_ORN:
          cond_next = cond_reg | litBit;
        ladder_pkg::FC_BLK_AND, ladder_pkg::FC_BLK_OR:
        begin
          // [RQ15] [RQ19] operate on saved conditions only
          if (stackEmpty)
            err_next = 1'b1;
          else
          begin
            // [RQ13] [RQ14] combine with top and pop
            cond_next = instr.func[0] ? (cond_reg | stack_reg[0]) : (cond_reg & stack_reg[0]);
            stack_next = {1'b0, stack_reg[STACK_DEPTH-1:1]};
            stackCnt_next = stackCnt_reg - CNT_W'(1);
          end
        end
        ladder_pkg::FC_OUT, ladder_pkg::FC_OUTN:
        begin
          // [RQ2] [RQ3] [RQ4] [RQ5] single-line output writes
          if (opValid && instr.chan == ladder_pkg::CH_OUT && int'(opIdx) < NUM_OUT)
            outImg_next[opIdx[3:0]] = outVal;
          if (opValid && instr.chan == ladder_pkg::CH_WORK)
            work_next[opIdx[3:0]] = outVal;
          lineStart_next = 1'b1;
        end
        default:
          lineStart_next = lineStart_reg;
      endcase
    end
  end

  // state registers
  always_ff @(posedge ref_clk)
  begin
    if (!nrst)
    begin
      state_reg <= SEEK_FETCH;
      pc_reg <= ladder_pkg::PROG_FIRST;
      endAddr_reg <= ladder_pkg::PROG_FIRST;
      cond_reg <= 1'b0;
      lineStart_reg <= 1'b1;
      stack_reg <= '0;
      stackCnt_reg <= '0;
      outImg_reg <= '0;
      work_reg <= ladder_pkg::IMAGE_RESET;
      err_reg <= 1'b0;
      done_reg <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      pc_reg <= pc_next;
      endAddr_reg <= endAddr_next;
      cond_reg <= cond_next;
      lineStart_reg <= lineStart_next;
      stack_reg <= stack_next;
      stackCnt_reg <= stackCnt_next;
      outImg_reg <= outImg_next;
      work_reg <= work_next;
      err_reg <= err_next;
      done_reg <= done_next;
    end
  end

  assign outPins = outImg_reg;
  assign progError = err_reg;
  assign scanDone = done_reg;
  assign running = (state_reg == RUN_FETCH) || execNow;

  default clocking @(posedge ref_clk); endclocking
  default disable iff (!nrst);

  wire logic outToBit = execNow && isOut && instr.chan == ladder_pkg::CH_OUT && opValid && opIdx < 5'(NUM_OUT);

  a_out_follows: assert property ( // [RQ2]
    outToBit && !instr.func[0] |=> outPins[$past(opIdx[3:0])] == $past(cond_reg))
    else $error("direct output does not follow condition");
  a_outnot_inverts: assert property ( // [RQ3]
    outToBit && instr.func[0] |=> outPins[$past(opIdx[3:0])] == !$past(cond_reg))
    else $error("inverted output does not oppose condition");
  a_series_and: assert property ( // [RQ1]
    execNow && instr.func == ladder_pkg::FC_ANDN |=> cond_reg == ($past(cond_reg) & !$past(opBit)))
    else $error("series negated condition wrong");
  a_load_push: assert property ( // [RQ11]
    execNow && isLoad && !lineStart_reg && stackCnt_reg != CNT_FULL
    |=> stackCnt_reg == $past(stackCnt_reg) + CNT_W'(1) && stack_reg[0] == $past(cond_reg))
    else $error("mid-line load did not save condition");
  a_first_nopush: assert property ( // [RQ12]
    execNow && !(isLoad && !lineStart_reg) |=> stackCnt_reg <= $past(stackCnt_reg))
    else $error("saved condition created without mid-line load");
  a_block_or: assert property ( // [RQ14]
    execNow && instr.func == ladder_pkg::FC_BLK_OR && !stackEmpty
    |=> cond_reg == ($past(cond_reg) | $past(stack_reg[0])) && stackCnt_reg == $past(stackCnt_reg) - CNT_W'(1))
    else $error("block-or result wrong");
  a_block_and: assert property ( // [RQ13]
    execNow && instr.func == ladder_pkg::FC_BLK_AND && !stackEmpty
    |=> cond_reg == ($past(cond_reg) & $past(stack_reg[0])) && stackCnt_reg == $past(stackCnt_reg) - CNT_W'(1))
    else $error("block-and result wrong");
  a_empty_error: assert property ( // [RQ19]
    execNow && isBlk && stackEmpty |=> progError && $stable(cond_reg))
    else $error("empty-stack block op mishandled");
  a_end_restart: assert property ( // [RQ6]
    execNow && isEnd |=> scanDone && state_reg == SEEK_FETCH && pc_reg == ladder_pkg::PROG_FIRST ##1 !running [*2])
    else $error("end did not restart the scan");
  a_no_past_end: assert property ( // [RQ7]
    running |-> pc_reg <= endAddr_reg)
    else $error("execution past first end");
  a_scan_clear: assert property ( // [RQ18]
    state_reg == SEEK_CHECK && isEnd |=> stackCnt_reg == '0 && lineStart_reg)
    else $error("stack not cleared at scan start");
endmodule

/* verification/io_image_model.sv */
// far-side input and output bit image of the controller
`timescale 1ns/100ps
module io_image_model (
  input wire logic ref_clk, // system clock
  input wire logic [15:0] drvVec, // input levels commanded by the bench
  output logic [15:0] inPins, // physical input lines
  input wire logic [15:0] outPins, // physical output lines
  output logic [15:0] outImage // output levels as latched by the far side
);
  // inputs are plain levels, held until the bench changes them
  assign inPins = drvVec;
  // far side latches the output lines each clock
  always_ff @(posedge ref_clk)
  begin
    outImage <= outPins;
  end
endmodule

/* verification/tb_ladder_bit_logic_evaluator.sv */
// self-checking bench for the ladder bit-logic evaluator
`timescale 1ns/100ps
module tb_ladder_bit_logic_evaluator;
  logic ref_clk;
  logic nrst;
  logic progWe;
  logic [7:0] progAddr;
  ladder_pkg::instr_s progData;
  logic [15:0] inVec;
  logic [15:0] inPins;
  logic [15:0] outPins;
  logic [15:0] outImage;
  logic running;
  logic scanDone;
  logic progError;
  logic sawRun;
  int num_errors = 0;
  int n_checks = 0;
  int cycles = 0;
  int period = 0;
  ladder_pkg::instr_s prog [22];
  // rows: input bits 3..0 beside output bits 4..0 they should give
  logic [3:0] rowIn [7] = '{4'h0, 4'h3, 4'h4, 4'hC, 4'h1, 4'h9, 4'h7};
  logic [4:0] rowOut [7] = '{5'h02, 5'h01, 5'h05, 5'h0E, 5'h0A, 5'h0E, 5'h01};

  ladder_bit_logic_evaluator dut_u (
    .ref_clk(ref_clk), .nrst(nrst), .inPins(inPins), .outPins(outPins), .progWe(progWe),
    .progAddr(progAddr), .progData(progData), .running(running), .scanDone(scanDone),
    .progError(progError)
  );
  io_image_model image_u (
    .ref_clk(ref_clk), .drvVec(inVec), .inPins(inPins), .outPins(outPins), .outImage(outImage)
  );

  // 250 MHz clock
  initial
  begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end

  function automatic ladder_pkg::instr_s mk(input logic [7:0] f, input logic [7:0] c, input logic [7:0] b);
    mk = '{func: f, chan: c, bitSel: b};
  endfunction

  task automatic tick();
    @(posedge ref_clk);
    #1;
  endtask

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("CHECK FAILED at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask

  task automatic write_word(input int a, input ladder_pkg::instr_s w);
    progWe = 1'b1;
    progAddr = a[7:0];
    progData = w;
    // strobe stays up; caller lowers it after the last word
    tick();
  endtask

  // waits for n scan-done pulses, keeps the last pulse spacing
  task automatic wait_scans(input int n);
    int k;
    k = 0;
    while (n > 0 && k < 1000)
    begin
      tick();
      k++;
      if (running === 1'b1) sawRun = 1'b1;
      if (scanDone === 1'b1)
      begin
        n--;
        period = k;
        k = 0;
      end
    end
    if (k >= 1000)
    begin
      num_errors++;
      $display("CHECK FAILED at %0t: seen %0h expected %0h", $time, n, 0);
    end
  endtask

  task automatic print_verdict();
    $display("checks %0d, errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // hang guard
  always @(posedge ref_clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      num_errors++;
      print_verdict();
    end
  end

  initial
  begin
    nrst = 1'b0;
    progWe = 1'b0;
    progAddr = 8'h00;
    progData = ladder_pkg::INSTR_RESET;
    inVec = 16'h0000;
    repeat (2) tick();
    check({13'h0000, running, scanDone, progError}, 16'h0000);
    check(outPins, 16'h0000);
    nrst = 1'b1;
    // memory is not reset: clear it to no-ops while the engine seeks
    for (int a = 0; a < ladder_pkg::PROG_WORDS; a++) write_word(a, ladder_pkg::INSTR_RESET);
    progWe = 1'b0;
    sawRun = 1'b0;
    repeat (400)
    begin
      tick();
      if (running !== 1'b0) sawRun = 1'b1;
    end
    check({15'h0000, sawRun}, 16'h0000);
    check(outPins, 16'h0000);
    prog = '{
      mk(ladder_pkg::FC_LD, 8'h00, 8'h00), mk(ladder_pkg::FC_AND, 8'h00, 8'h01),
      mk(ladder_pkg::FC_OR, 8'h00, 8'h02), mk(ladder_pkg::FC_ANDN, 8'h00, 8'h03),
      mk(ladder_pkg::FC_OUT, 8'h01, 8'h00), mk(ladder_pkg::FC_OUTN, 8'h01, 8'h01),
      mk(ladder_pkg::FC_LDN, 8'h00, 8'h00), mk(ladder_pkg::FC_ORN, 8'h00, 8'h01),
      mk(ladder_pkg::FC_LD, 8'h00, 8'h02), mk(ladder_pkg::FC_OR, 8'h00, 8'h03),
      mk(ladder_pkg::FC_BLK_AND, 8'h00, 8'h00), mk(ladder_pkg::FC_OUT, 8'h01, 8'h02),
      mk(ladder_pkg::FC_LD, 8'h00, 8'h00), mk(ladder_pkg::FC_ANDN, 8'h00, 8'h01),
      mk(ladder_pkg::FC_LD, 8'h00, 8'h02), mk(ladder_pkg::FC_AND, 8'h00, 8'h03),
      mk(ladder_pkg::FC_BLK_OR, 8'h00, 8'h00), mk(ladder_pkg::FC_OUT, 8'h01, 8'h03),
      mk(ladder_pkg::FC_END, 8'h00, 8'h00), mk(ladder_pkg::FC_LDN, 8'h00, 8'h15),
      mk(ladder_pkg::FC_OUT, 8'h01, 8'h04), mk(ladder_pkg::FC_END, 8'h00, 8'h00)};
    for (int a = 0; a < 22; a++) write_word(a, prog[a]);
    progWe = 1'b0;
    wait_scans(2);
    // scan: search and run both stop at the first end, two cycles a word
    check(period[15:0], 16'h004C);
    check({15'h0000, sawRun}, 16'h0001);
    // one loop over the ordinary rows
    for (int r = 0; r < 7; r++)
    begin
      inVec = {12'h000, rowIn[r]};
      repeat (3) tick();
      wait_scans(2);
      check(outImage, {11'h000, rowOut[r]});
    end
    check({15'h0000, progError}, 16'h0000);
    // move the end: empty-stack block op, then outputs of formerly dead code
    inVec = 16'h000C;
    write_word(18, mk(ladder_pkg::FC_BLK_AND, 8'h00, 8'h00));
    write_word(19, mk(ladder_pkg::FC_OUT, 8'h01, 8'h05));
    progWe = 1'b0;
    wait_scans(3);
    check(outImage, 16'h003E);
    check({15'h0000, progError}, 16'h0001);
    check(period[15:0], 16'h0058);
    // second reset in the cycle after a scan-done pulse, while the engine seeks
    nrst = 1'b0;
    tick();
    check({progError, outPins[14:0]}, 16'h0000);
    nrst = 1'b1;
    wait_scans(2);
    check(outImage, 16'h003E);
    print_verdict();
  end
endmodule
